// ---- cti_pkg.sv ----
// constants, enumerations and carrier types shared by the co2 threshold indicator.
// assumes a single 40 mhz system clock; concentrations arrive as signed ppm values.
package cti_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned BLINK_HALF_MS    = 500;
    // half-period of the blink, also the base tick of all screen timing
    localparam int unsigned HALF_SEC_CYCLES  = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int unsigned TICK_W           = 25;
    // screens and errors stay up for three seconds (six half-second ticks)
    localparam logic [2:0]  SCREEN_HOLD_TICKS = 3'h6;

    // ************************************************************
    // concentration thresholds in ppm
    // ************************************************************
    localparam logic signed [15:0] HYST_PPM   = 16'sh0032;  // 50
    localparam logic signed [15:0] FAIR_PPM   = 16'sh0320;  // 800
    localparam logic signed [15:0] POOR_PPM   = 16'sh04b0;  // 1200
    localparam logic signed [15:0] BLINK_PPM  = 16'sh07d0;  // 2000

    // ************************************************************
    // analog output scaling, co2 in ppm and temperature in 0.1 degc
    // ************************************************************
    localparam logic signed [15:0] CO2_LO     = 16'sh0000;
    localparam logic signed [15:0] CO2_HI     = 16'sh07d0;
    localparam logic signed [15:0] CO2_ERR_LO = 16'shff38;  // -200
    localparam logic signed [15:0] CO2_ERR_HI = 16'sh0bb8;  // 3000
    localparam logic signed [15:0] T_LO       = 16'sh0000;
    localparam logic signed [15:0] T_HI       = 16'sh01f4;  // 50.0
    localparam logic signed [15:0] T_ERR_LO   = 16'shff9c;  // -10.0
    localparam logic signed [15:0] T_ERR_HI   = 16'sh0258;  // 60.0

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {cti_scr_info, cti_scr_outputs, cti_scr_meas} cti_screen_type;
    typedef enum logic [1:0] {cti_lvl_good, cti_lvl_fair, cti_lvl_poor, cti_lvl_severe}
        cti_level_type;

    typedef struct packed {
        logic red;
        logic yellow;
        logic green;
    } cti_lamps_type;

    typedef struct packed {
        logic co2;
        logic temp;
        logic rh;
    } cti_stars_type;

    typedef struct packed {
        logic                 relay;
        cti_level_type        level;
        cti_lamps_type        lamps;
        logic                 blink;
        cti_screen_type       screen;
        logic [2:0]           hold;
        logic                 out_sel;
        logic                 su_err;
        logic [3:0]           su_cause;
        logic                 show_sn;
        logic [1:0]           err_sel;
        logic [2:0]           err_hold;
        cti_stars_type        stars;
        logic                 alarm;
        logic signed [15:0]   temp_c;
    } cti_state_type;

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic              tick;
    } cti_tick_state_type;

    typedef struct packed {
        logic signed [15:0] code;
        logic               err;
    } cti_clip_state_type;

    // rotary selector decode; unused codes fall back to the default position
    function automatic logic signed [15:0] cti_setpoint(input logic [3:0] sel);
        logic signed [15:0] sp;
        unique case (sel)
            4'h1:    sp = 16'sh02bc;   // 700
            4'h2:    sp = 16'sh0320;   // 800
            4'h3:    sp = 16'sh0384;   // 900
            4'h4:    sp = 16'sh03e8;   // 1000
            4'h5:    sp = 16'sh04b0;   // 1200
            4'h6:    sp = 16'sh0578;   // 1400
            4'h7:    sp = 16'sh0640;   // 1600
            4'h8:    sp = 16'sh0708;   // 1800
            4'h9:    sp = 16'sh07d0;   // 2000
            default: sp = 16'sh0258;   // 600, position 0
        endcase
        return sp;
    endfunction : cti_setpoint

endpackage : cti_pkg

// ---- cti_tick.sv ----
// free-running divider giving a one-cycle enable pulse every TICK_CYCLES clocks.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module cti_tick #(
    parameter int unsigned TICK_CYCLES = cti_pkg::HALF_SEC_CYCLES
) (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    output var  logic tick_out
);

    cti_pkg::cti_tick_state_type r_reg;
    cti_pkg::cti_tick_state_type r_next;

    // ************************************************************
    // divider
    // ************************************************************
    // count wraps at the period and fires the enable for one cycle
    always_comb begin
        r_next      = r_reg;
        r_next.tick = 1'b0;
        if (r_reg.cnt == cti_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            r_next.cnt  = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick_out = r_reg.tick;

endmodule : cti_tick

`default_nettype wire

// ---- cti_clip.sv ----
// analog output code conditioner: clips into the scaled range, flags the error state.
// assumes the measured value is valid whenever it is sampled.
`timescale 1ns/10ps
`default_nettype none

module cti_clip #(
    parameter logic signed [15:0] LO     = 16'sh0000,
    parameter logic signed [15:0] HI     = 16'sh07d0,
    parameter logic signed [15:0] ERR_LO = 16'shff38,
    parameter logic signed [15:0] ERR_HI = 16'sh0bb8
) (
    input  wire logic               sys_clk_in,
    input  wire logic               rstn_in,
    input  wire logic               valid_in,
    input  wire logic signed [15:0] value_in,
    output var  logic signed [15:0] code_out,
    output var  logic               err_out
);

    cti_pkg::cti_clip_state_type r_reg;
    cti_pkg::cti_clip_state_type r_next;

    // ************************************************************
    // clipping
    // ************************************************************
    // error state is flagged alongside clipping; code still takes the clipped value
    always_comb begin
        r_next = r_reg;
        if (valid_in) begin
            r_next.err = (value_in < ERR_LO) || (value_in > ERR_HI);
            if (value_in > HI) begin
                r_next.code = HI;
            end else if (value_in < LO) begin
                r_next.code = LO;
            end else begin
                r_next.code = value_in;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            r_reg <= '{code: LO, err: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign code_out = r_reg.code;
    assign err_out  = r_reg.err;

    a_clip_top: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && value_in > HI |=> code_out == HI) else $error("top clip missing");
    a_clip_bottom: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && value_in < LO |=> code_out == LO) else $error("bottom clip missing");
    a_clip_error: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in |=> err_out == ($past(value_in) > ERR_HI || $past(value_in) < ERR_LO))
        else $error("error state wrong");

endmodule : cti_clip

`default_nettype wire

// ---- cti_indicator.sv ----
// co2 threshold indicator: relay, level lamps, air quality, display sequencing, outputs.
// assumes samples from the measurement module are qualified by meas_valid_in.
`timescale 1ns/10ps
`default_nettype none

module cti_indicator #(
    parameter int unsigned HALF_SEC_CYCLES = cti_pkg::HALF_SEC_CYCLES
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rstn_in,
    input  wire logic                    meas_valid_in,
    input  wire logic signed [15:0]      co2_ppm_in,
    input  wire logic signed [15:0]      temp_c_in,
    input  wire logic [3:0]              setpoint_sel_in,
    input  wire logic [3:0]              fault_in,
    input  wire logic                    module_present_in,
    input  wire logic [1:0]              outputs_active_in,
    output var  logic                    relay_out,
    output var  logic                    relay_lamp_out,
    output var  cti_pkg::cti_lamps_type  lamps_out,
    output var  cti_pkg::cti_level_type  air_class_out,
    output var  cti_pkg::cti_screen_type screen_out,
    output var  logic                    output_sel_out,
    output var  logic                    startup_err_out,
    output var  logic [3:0]              startup_cause_out,
    output var  logic                    show_module_sn_out,
    output var  logic [1:0]              err_shown_out,
    output var  logic                    alarm_out,
    output var  cti_pkg::cti_stars_type  stars_out,
    output var  logic signed [15:0]      temp_c_out,
    output var  logic signed [15:0]      co2_code_out,
    output var  logic                    co2_err_out,
    output var  logic signed [15:0]      temp_code_out,
    output var  logic                    temp_err_out
);

    cti_pkg::cti_state_type r_reg;
    cti_pkg::cti_state_type r_next;
    logic                   tick;
    logic signed [15:0]     sp;
    logic signed [15:0]     on_lvl;
    logic signed [15:0]     off_lvl;

    // ************************************************************
    // helpers
    // ************************************************************
    // half-second enable shared by blink, screen and error timing
    cti_tick #(
        .TICK_CYCLES (HALF_SEC_CYCLES)
    ) u_tick (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .tick_out   (tick)
    );

    // co2 and temperature analog codes
    cti_clip #(
        .LO     (cti_pkg::CO2_LO),
        .HI     (cti_pkg::CO2_HI),
        .ERR_LO (cti_pkg::CO2_ERR_LO),
        .ERR_HI (cti_pkg::CO2_ERR_HI)
    ) u_co2_clip (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .valid_in   (meas_valid_in),
        .value_in   (co2_ppm_in),
        .code_out   (co2_code_out),
        .err_out    (co2_err_out)
    );

    cti_clip #(
        .LO     (cti_pkg::T_LO),
        .HI     (cti_pkg::T_HI),
        .ERR_LO (cti_pkg::T_ERR_LO),
        .ERR_HI (cti_pkg::T_ERR_HI)
    ) u_temp_clip (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .valid_in   (meas_valid_in),
        .value_in   (temp_c_in),
        .code_out   (temp_code_out),
        .err_out    (temp_err_out)
    );

    // setpoint and band edges; table tops out at 2000 so no overflow in 16 bits
    assign sp      = cti_pkg::cti_setpoint(setpoint_sel_in);
    assign on_lvl  = sp + cti_pkg::HYST_PPM;
    assign off_lvl = sp - cti_pkg::HYST_PPM;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [1:0] cand;
        logic       found;
        r_next = r_reg;
        cand   = '0;
        found  = 1'b0;

        // relay with hysteresis, re-evaluated on each sample
        if (meas_valid_in) begin
            if (!r_reg.relay && co2_ppm_in > on_lvl) begin
                r_next.relay = 1'b1;
            end else if (r_reg.relay && co2_ppm_in < off_lvl) begin
                r_next.relay = 1'b0;
            end
            // 800 and 1200 fall into the upper class, 2000 into the lower
            if (co2_ppm_in > cti_pkg::BLINK_PPM) begin
                r_next.level = cti_pkg::cti_lvl_severe;
            end else if (co2_ppm_in >= cti_pkg::POOR_PPM) begin
                r_next.level = cti_pkg::cti_lvl_poor;
            end else if (co2_ppm_in >= cti_pkg::FAIR_PPM) begin
                r_next.level = cti_pkg::cti_lvl_fair;
            end else begin
                r_next.level = cti_pkg::cti_lvl_good;
            end
            r_next.temp_c = temp_c_in;
        end

        // blink toggles every half second: 1 s period, even duty
        if (tick) begin
            r_next.blink = ~r_reg.blink;
        end

        // lamps decoded from the level; at most one lit at a time
        r_next.lamps.green  = (r_next.level == cti_pkg::cti_lvl_good);
        r_next.lamps.yellow = (r_next.level == cti_pkg::cti_lvl_fair);
        r_next.lamps.red    = (r_next.level == cti_pkg::cti_lvl_poor) ||
                              ((r_next.level == cti_pkg::cti_lvl_severe) && r_next.blink);

        // fault markers on the display
        r_next.stars.co2  = fault_in[0];
        r_next.stars.temp = fault_in[1];
        r_next.stars.rh   = fault_in[2];

        // screen hold counter, shared by all startup screens
        if (tick && r_reg.screen != cti_pkg::cti_scr_meas) begin
            r_next.hold = r_reg.hold + 3'h1;
        end

        unique case (r_reg.screen)
            cti_pkg::cti_scr_info: begin
                // gather status during the whole first screen
                r_next.show_sn  = module_present_in;
                r_next.su_cause = r_reg.su_cause | fault_in;
                r_next.su_err   = r_reg.su_err | (|fault_in) | ~module_present_in;
                if (tick && r_reg.hold == cti_pkg::SCREEN_HOLD_TICKS - 3'h1) begin
                    r_next.hold = '0;
                    if (|outputs_active_in) begin
                        r_next.screen  = cti_pkg::cti_scr_outputs;
                        r_next.out_sel = ~outputs_active_in[0];
                    end else begin
                        r_next.screen = cti_pkg::cti_scr_meas;
                    end
                end
            end
            cti_pkg::cti_scr_outputs: begin
                if (tick && r_reg.hold == cti_pkg::SCREEN_HOLD_TICKS - 3'h1) begin
                    r_next.hold = '0;
                    if (!r_reg.out_sel && outputs_active_in[1]) begin
                        r_next.out_sel = 1'b1;
                    end else begin
                        r_next.screen   = cti_pkg::cti_scr_meas;
                        // open on the cause found at startup
                        r_next.err_hold = '0;
                        for (int i = 0; i < 4; i++) begin
                            if (!found && r_reg.su_cause[i]) begin
                                r_next.err_sel = 2'(i);
                                found          = 1'b1;
                            end
                        end
                    end
                end
            end
            cti_pkg::cti_scr_meas: begin
                r_next.alarm = |fault_in;
                if (tick) begin
                    r_next.err_hold = r_reg.err_hold + 3'h1;
                end
                // drop a stale error at once, else advance after the hold
                if (|fault_in && (!fault_in[r_reg.err_sel] ||
                    (tick && r_reg.err_hold == cti_pkg::SCREEN_HOLD_TICKS - 3'h1))) begin
                    r_next.err_hold = '0;
                    for (int i = 1; i <= 4; i++) begin
                        cand = r_reg.err_sel + 2'(i);
                        if (!found && fault_in[cand]) begin
                            r_next.err_sel = cand;
                            found          = 1'b1;
                        end
                    end
                end
            end
            default: begin
                r_next.screen = cti_pkg::cti_scr_info;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // these outputs taken straight from the state register; analog codes and errors come from the clip registers
    assign relay_out          = r_reg.relay;
    assign relay_lamp_out     = r_reg.relay;
    assign lamps_out          = r_reg.lamps;
    assign air_class_out      = r_reg.level;
    assign screen_out         = r_reg.screen;
    assign output_sel_out     = r_reg.out_sel;
    assign startup_err_out    = r_reg.su_err;
    assign startup_cause_out  = r_reg.su_cause;
    assign show_module_sn_out = r_reg.show_sn;
    assign err_shown_out      = r_reg.err_sel;
    assign alarm_out          = r_reg.alarm;
    assign stars_out          = r_reg.stars;
    assign temp_c_out         = r_reg.temp_c;

    // ************************************************************
    // checks
    // ************************************************************
    a_relay_close: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        meas_valid_in && co2_ppm_in > on_lvl |=> relay_out) else $error("relay not closed");
    a_relay_band: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !relay_out && meas_valid_in && co2_ppm_in <= on_lvl |=> !relay_out)
        else $error("relay closed inside band");
    a_relay_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        relay_out && meas_valid_in && co2_ppm_in >= off_lvl |=> relay_out)
        else $error("relay released early");
    a_relay_lamp: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        relay_lamp_out == relay_out) else $error("relay lamp mismatch");
    a_red_blink: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        meas_valid_in && co2_ppm_in > cti_pkg::BLINK_PPM |=> lamps_out.red == r_reg.blink &&
        !lamps_out.yellow && !lamps_out.green) else $error("red lamp not blinking");
    a_yellow_band: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        meas_valid_in && co2_ppm_in >= cti_pkg::FAIR_PPM && co2_ppm_in < cti_pkg::POOR_PPM
        |=> lamps_out == 3'b010 && air_class_out == cti_pkg::cti_lvl_fair)
        else $error("fair band wrong");
    a_green_band: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        meas_valid_in && co2_ppm_in < cti_pkg::FAIR_PPM |=> lamps_out == 3'b001)
        else $error("green band wrong");
    a_poor_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        meas_valid_in && co2_ppm_in >= cti_pkg::POOR_PPM |=>
        air_class_out inside {cti_pkg::cti_lvl_poor, cti_pkg::cti_lvl_severe})
        else $error("poor class missing");
    a_one_lamp: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $countones(lamps_out) <= 1) else $error("several lamps lit");
    a_blink_period: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        tick |=> r_reg.blink != $past(r_reg.blink)) else $error("blink missed tick");
    a_screen_order: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        screen_out != cti_pkg::cti_scr_info |=> screen_out != cti_pkg::cti_scr_info)
        else $error("screen order broken");
    a_alarm_fault: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        screen_out == cti_pkg::cti_scr_meas && |fault_in |=> alarm_out &&
        stars_out == {$past(fault_in[0]), $past(fault_in[1]), $past(fault_in[2])})
        else $error("fault not shown");

    c_relay_on: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $rose(relay_out));
    c_red_blink: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        air_class_out == cti_pkg::cti_lvl_severe && $fell(lamps_out.red));
    c_meas_screen: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $changed(screen_out) && screen_out == cti_pkg::cti_scr_meas);
    c_err_rotate: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        screen_out == cti_pkg::cti_scr_meas && $changed(err_shown_out));

endmodule : cti_indicator

`default_nettype wire

// ---- cti_meas_model.sv ----
// measurement module model: presents one co2 sample while req_in is high.
// assumes the bench moves req_in and ppm_in together, off the rising edge.
`timescale 1ns/10ps
`default_nettype none
module cti_meas_model (
    input  wire logic               req_in,
    input  wire logic signed [15:0] ppm_in,
    output var  logic               valid_out,
    output var  logic signed [15:0] co2_out
);
    logic signed [15:0] last_reg = 16'sh0000;
    // idle bus shows the inverse, so stale data is never mistaken for a sample
    // continuous assigns settle at time zero, so valid is never unknown after reset
    always @(req_in or ppm_in) if (req_in) last_reg = ppm_in;
    assign valid_out = req_in;
    assign co2_out   = req_in ? ppm_in : ~last_reg;
endmodule : cti_meas_model
`default_nettype wire

// ---- tb_cti_indicator.sv ----
// self-checking bench: directed and random samples, checked through a queue.
// assumes a short half-second tick so the screens finish early.
`timescale 1ns/10ps
`default_nettype none
module tb_cti_indicator;
    logic                   sys_clk_in = 1'b0;
    logic                   rstn_in    = 1'b0;
    logic                   req        = 1'b0;
    logic                   took       = 1'b0;
    logic                   rel        = 1'b0;
    logic signed [15:0]     ppm        = 16'sh0000;
    logic [3:0]             sel        = 4'h4;
    logic [3:0]             fault      = 4'h0;
    logic [21:0]            e;
    logic [21:0]            q[$];
    logic                   mv, relay, lamp, cerr, alarm, osel, serr, ssn, terr;
    logic                   present    = 1'b1;
    logic [1:0]             outs       = 2'h3;
    logic [1:0]             eshown;
    logic [3:0]             scause;
    logic [32:0]            et;
    logic [32:0]            qt[$];
    logic signed [15:0]     co2, code, tc, tcode;
    logic signed [15:0]     tmp        = 16'sh0000;
    cti_pkg::cti_lamps_type lamps;
    cti_pkg::cti_level_type cls;
    cti_pkg::cti_screen_type scr;
    cti_pkg::cti_stars_type stars;
    int                     err_total = 0;
    int                     tests_run = 0;
    int                     seed = 53810;
    int                     dir[11] = '{1050, 1051, 950, 949, 799, 800, 1199, 1200, 2000, -201, 3001};
    cti_meas_model meas (.req_in(req), .ppm_in(ppm), .valid_out(mv), .co2_out(co2));
    cti_indicator #(.HALF_SEC_CYCLES(4)) dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .meas_valid_in(mv), .co2_ppm_in(co2), .temp_c_in(tmp), .setpoint_sel_in(sel),
        .fault_in(fault), .module_present_in(present), .outputs_active_in(outs),
        .relay_out(relay), .relay_lamp_out(lamp), .lamps_out(lamps), .air_class_out(cls),
        .screen_out(scr), .output_sel_out(osel), .startup_err_out(serr),
        .startup_cause_out(scause), .show_module_sn_out(ssn), .err_shown_out(eshown),
        .alarm_out(alarm), .stars_out(stars), .temp_c_out(tc), .co2_code_out(code),
        .co2_err_out(cerr), .temp_code_out(tcode), .temp_err_out(terr));
    initial forever #12.5 sys_clk_in = ~sys_clk_in;
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
        tests_run++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, x, s);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    // notes the expected outcome, then holds the sample for one cycle
    task automatic sample(input int v);
        int s, c, t;
        s = (sel == 0 || sel > 9) ? 600 : sel < 5 ? 600 + 100 * sel : 1200 + 200 * (sel - 5);
        if (v > s + 50) rel = 1'b1;
        else if (v < s - 50) rel = 1'b0;
        c = v > 2000 ? 3 : v >= 1200 ? 2 : v >= 800 ? 1 : 0;
        q.push_back({rel, c == 1, c == 0, c[1:0], v < -200 || v > 3000,
                     v < 0 ? 16'h0000 : v > 2000 ? 16'h07d0 : v[15:0]});
        // temperature follows the sweep, reaching both clip ends and the error state
        t = v / 4 - 200;
        qt.push_back({t < -100 || t > 600, t < 0 ? 16'h0000 : t > 500 ? 16'h01f4 : t[15:0],
                      t[15:0]});
        req <= 1'b1;
        ppm <= v[15:0];
        tmp <= t[15:0];
        @(negedge sys_clk_in);
    endtask : sample
    // ************************************************************
    // monitor: one note per taken sample, compared a half cycle later
    // ************************************************************
    always @(posedge sys_clk_in) took <= mv;
    always @(negedge sys_clk_in) if (took) begin
        e = q.pop_front();
        check("relay", relay, e[21]);
        check("relay_lamp", lamp, e[21]);
        check("yellow", lamps.yellow, e[20]);
        check("green", lamps.green, e[19]);
        check("class", cls, e[18:17]);
        if (e[18:17] == 2'h2) check("red", lamps.red, 1'b1);
        check("co2_err", cerr, e[16]);
        if (!e[16]) check("co2_code", code, e[15:0]);
        et = qt.pop_front();
        check("temp_c", tc, et[15:0]);
        check("temp_err", terr, et[32]);
        if (!et[32]) check("temp_code", tcode, et[31:16]);
    end
    initial begin
        #(25 * 4000);
        err_total++;
        close_out();
    end
    initial begin
        repeat (16) @(negedge sys_clk_in);
        rstn_in <= 1'b1;
        @(negedge sys_clk_in);
        foreach (dir[k]) sample(dir[k]);
        for (int i = 0; i < 300; i++) begin
            if ($random(seed) & 1) begin
                req <= 1'b0;
                sel = 4'($random(seed));
                @(negedge sys_clk_in);
            end
            sample(-400 + ($random(seed) & 4095));
        end
        req <= 1'b0;
        fault <= 4'h3;
        repeat (3) @(negedge sys_clk_in);
        check("screen", scr, cti_pkg::cti_scr_meas);
        check("stars", stars, 3'h6);
        check("alarm", alarm, 1'b1);
        check("output_sel", osel, 1'b1);
        check("startup_err", serr, 1'b0);
        check("show_sn", ssn, 1'b1);
        // second reset: module absent, one fault, no active outputs
        rstn_in <= 1'b0;
        fault <= 4'h4;
        present <= 1'b0;
        outs <= 2'h0;
        repeat (16) @(negedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        check("startup_err", serr, 1'b1);
        check("show_sn", ssn, 1'b0);
        check("startup_cause", scause, 4'h4);
        check("screen_info", scr, cti_pkg::cti_scr_info);
        repeat (30) @(negedge sys_clk_in);
        check("screen", scr, cti_pkg::cti_scr_meas);
        check("err_shown", eshown, 2'h2);
        check("stars", stars, 3'h1);
        check("alarm", alarm, 1'b1);
        close_out();
    end
endmodule : tb_cti_indicator
`default_nettype wire
